/* hdl/isc_pkg.sv */
/*
 * isc_pkg: shared constants of the impulse count / serial control block.
 * Assumes both ends and the link interface compile after it; nothing is imported.
 */
package isc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 250;        // sys_clk rate
    localparam int DEAD_SEVEN_MS  = 143;        // seven counts per second
    localparam int DEAD_CCITT_MS  = 125;        // eight counts per second
    localparam int DEAD_CAL_MS    = 10;         // shorter calibration dead time
    localparam int DEAD_SEVEN_CYC = DEAD_SEVEN_MS * CLK_MHZ * 1000;
    localparam int DEAD_CCITT_CYC = DEAD_CCITT_MS * CLK_MHZ * 1000;
    localparam int DEAD_CAL_CYC   = DEAD_CAL_MS * CLK_MHZ * 1000;
    localparam int POLL_S         = 1;          // counter poll interval
    localparam int POLL_CYC       = POLL_S * CLK_MHZ * 1000000;
    localparam int TIMER_W        = 28;         // width of long timers
    localparam int SCK_HALF_CYC   = 2;          // shift clock half period
    localparam int LATCH_CYC      = 4;          // latch pulse width, > sync delay

    // ------------------------------------------------------------------
    // stream layout: switch word first, threshold code last
    // ------------------------------------------------------------------
    localparam int SW_W           = 8;          // switch holding register width
    localparam int THR_W          = 6;          // 60 steps of .25 dB = 15 dB
    localparam int STREAM_W       = SW_W + THR_W;
    localparam int CNT_W          = 4;          // impulse counter width

    // switch word bit positions
    localparam int SWB_WEIGHTED   = 0;
    localparam int SWB_GAIN15     = 1;
    localparam int SWB_GAIN30     = 2;
    localparam int SWB_AVERAGING_SELECT    = 3;
    localparam int SWB_CAL_GATE   = 4;
    localparam int SWB_CAL_DEAD   = 5;
    localparam int SWB_MODE_LO    = 6;          // two-bit measurement mode
    localparam logic [SW_W-1:0]  SW_RESET  = 8'h00;
    localparam logic [THR_W-1:0] THR_RESET = 6'h00;

    // measurement modes carried in the switch word
    localparam logic [1:0] MODE_LEVEL      = 2'h0;
    localparam logic [1:0] MODE_NOISE_TONE = 2'h1;
    localparam logic [1:0] MODE_IMPULSE    = 2'h2;
    localparam logic [1:0] MODE_JITTER     = 2'h3;

endpackage : isc_pkg

/* hdl/isc_link_if.sv */
/*
 * isc_link_if: the wires between the controller end and the board end.
 * Assumes the bench instantiates it and hands one modport to each end.
 */
`timescale 1ns/1ps
`default_nettype none
interface isc_link_if;
    logic                          option_shift_clock;  // shift clock, made by controller
    logic                          serial_data;         // stream bit, valid at rising edge
    logic                          latch_strobe;        // copies shifted bits to holders
    logic [isc_pkg::CNT_W-1:0]     count_gray;          // impulse counter, gray coded

    modport dev  (input option_shift_clock, input serial_data, input latch_strobe,
                  output count_gray);
    modport host (output option_shift_clock, output serial_data, output latch_strobe,
                  input count_gray);
endinterface : isc_link_if
`default_nettype wire

/* hdl/isc_sync2.sv */
/*
 * isc_sync2: two flip-flop synchroniser for levels or gray words.
 * Assumes the input changes at most one bit at a time when wider than one.
 */
`timescale 1ns/1ps
`default_nettype none
module isc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    // ------------------------------------------------------------------
    // two stages; the first is read by the second only
    // ------------------------------------------------------------------
    logic [W-1:0] meta;  // metastable stage

    // both stages clear under reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : isc_sync2
`default_nettype wire

/* hdl/isc_board.sv */
/*
 * isc_board: board end. Impulse dead-time and counter, serial option
 * shifter on the link clock, holding registers and analog switch decode.
 * Assumes the controller stops the shift clock before it raises the latch,
 * and that comparator and oscillator inputs are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module isc_board #(
    parameter bit CCITT_VARIANT = 1'b0,                    // 0: 143 ms, 1: 125 ms
    parameter int DEAD_SEVEN    = isc_pkg::DEAD_SEVEN_CYC, // long counts, shortenable
    parameter int DEAD_CCITT    = isc_pkg::DEAD_CCITT_CYC,
    parameter int DEAD_CAL      = isc_pkg::DEAD_CAL_CYC
) (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    isc_link_if.dev                          link,
    input  wire logic                        threshold_comparator,
    input  wire logic                        calibration_oscillator_signal,
    output logic [isc_pkg::THR_W-1:0]        threshold_dac,
    output logic [isc_pkg::CNT_W-1:0]        impulse_counter,
    output logic                             dead_time_oneshot,
    output logic                             weighting_filter_en,
    output logic                             unweighted_amp_en,
    output logic                             notch_en,
    output logic                             gain15_en,
    output logic                             gain30_en,
    output logic                             rms_long_tc_en,
    output logic                             calibration_oscillator_signal_out
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // notch stays in for tone-removal and impulse work only
    function automatic logic notch_for_mode(input logic [1:0] mode);
        return (mode == isc_pkg::MODE_NOISE_TONE) || (mode == isc_pkg::MODE_IMPULSE);
    endfunction : notch_for_mode

    // ------------------------------------------------------------------
    // link domain: cascaded shift registers
    // ------------------------------------------------------------------
    logic [isc_pkg::THR_W-1:0] first_shift_register;       // receives the stream
    logic [isc_pkg::SW_W-1:0]  second_shift_register;      // fed from the first
    logic [isc_pkg::THR_W-1:0] next_first;
    logic [isc_pkg::SW_W-1:0]  next_second;

    // one bit in per rising shift clock edge, carried across both stages
    always_comb begin
        next_first  = {first_shift_register[isc_pkg::THR_W-2:0], link.serial_data};
        next_second = {second_shift_register[isc_pkg::SW_W-2:0],
                       first_shift_register[isc_pkg::THR_W-1]};
    end

    // contents need no reset value, but a defined one helps the bench
    always_ff @(posedge link.option_shift_clock or posedge sys_rst) begin
        if (sys_rst) begin
            first_shift_register  <= '0;
            second_shift_register <= '0;
        end else begin
            first_shift_register  <= next_first;
            second_shift_register <= next_second;
        end
    end

    // ------------------------------------------------------------------
    // system domain: latch and comparator synchronisers
    // ------------------------------------------------------------------
    logic latch_s;      // latch strobe after two flops
    logic comp_s;       // comparator after two flops

    isc_sync2 #(.W(1)) u_sync_latch (
        .clk  (sys_clk),
        .rst  (sys_rst),
        .din  (link.latch_strobe),
        .dout (latch_s)
    );

    isc_sync2 #(.W(1)) u_sync_comp (
        .clk  (sys_clk),
        .rst  (sys_rst),
        .din  (threshold_comparator),
        .dout (comp_s)
    );

    // ------------------------------------------------------------------
    // holding registers
    // ------------------------------------------------------------------
    logic [isc_pkg::SW_W-1:0]  switch_holding_register;
    logic [isc_pkg::THR_W-1:0] threshold_holding_register;
    logic                      latch_d;                     // previous latch level
    logic [isc_pkg::SW_W-1:0]  next_switch;
    logic [isc_pkg::THR_W-1:0] next_thresh;
    logic                      latch_rise;

    // the shifter is static while the latch is high because the shift
    // clock has stopped, so copying the words across here is safe
    always_comb begin
        latch_rise  = latch_s && !latch_d;
        next_switch = switch_holding_register;
        next_thresh = threshold_holding_register;
        if (latch_rise) begin
            next_switch = second_shift_register;
            next_thresh = first_shift_register;
        end
    end

    // holders only register the values chosen above
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            switch_holding_register    <= isc_pkg::SW_RESET;
            threshold_holding_register <= isc_pkg::THR_RESET;
            latch_d                    <= 1'b0;
        end else begin
            switch_holding_register    <= next_switch;
            threshold_holding_register <= next_thresh;
            latch_d                    <= latch_s;
        end
    end

    // ------------------------------------------------------------------
    // dead-time one-shot and impulse counter
    // ------------------------------------------------------------------
    logic                      comp_d;           // previous comparator level
    logic [isc_pkg::TIMER_W-1:0] dead_cnt;       // cycles left in the dead time
    logic [isc_pkg::TIMER_W-1:0] next_dead_cnt;
    logic [isc_pkg::TIMER_W-1:0] dead_load;      // interval for this firing
    logic [isc_pkg::CNT_W-1:0] next_count;
    logic [isc_pkg::CNT_W-1:0] count_gray;
    logic                      fire;

    // a rise while the one-shot runs is dropped, not deferred
    always_comb begin
        if (switch_holding_register[isc_pkg::SWB_CAL_DEAD])
            dead_load = DEAD_CAL[isc_pkg::TIMER_W-1:0];
        else if (CCITT_VARIANT)
            dead_load = DEAD_CCITT[isc_pkg::TIMER_W-1:0];
        else
            dead_load = DEAD_SEVEN[isc_pkg::TIMER_W-1:0];
        fire          = comp_s && !comp_d && (dead_cnt == '0);
        next_dead_cnt = dead_cnt;
        next_count    = impulse_counter;
        if (fire) begin
            next_dead_cnt = dead_load;
            next_count    = impulse_counter + 4'h1;
        end else if (dead_cnt != '0) begin
            next_dead_cnt = dead_cnt - 28'h0000001;
        end
    end

    // counter and timer registers; gray copy feeds the controller
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            comp_d          <= 1'b0;
            dead_cnt        <= '0;
            impulse_counter <= 4'h0;
            count_gray      <= 4'h0;
        end else begin
            comp_d          <= comp_s;
            dead_cnt        <= next_dead_cnt;
            impulse_counter <= next_count;
            count_gray      <= next_count ^ (next_count >> 1);   // one bit per step
        end
    end

    // gray coding lets the controller resample the count on a foreign
    // clock: only one bit moves per step, so no torn value is ever seen
    assign link.count_gray = count_gray;
    assign dead_time_oneshot = (dead_cnt != '0);

    // ------------------------------------------------------------------
    // analog switch decode from the holding registers
    // ------------------------------------------------------------------
    logic osc_s;   // oscillator seen after two flops

    isc_sync2 #(.W(1)) u_sync_osc (
        .clk  (sys_clk),
        .rst  (sys_rst),
        .din  (calibration_oscillator_signal),
        .dout (osc_s)
    );

    // every control is a flop so switches never glitch on decode
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            threshold_dac       <= isc_pkg::THR_RESET;
            weighting_filter_en <= 1'b0;
            unweighted_amp_en   <= 1'b1;
            notch_en            <= 1'b0;
            gain15_en           <= 1'b0;
            gain30_en           <= 1'b0;
            rms_long_tc_en      <= 1'b0;
            calibration_oscillator_signal_out         <= 1'b0;
        end else begin
            threshold_dac       <= threshold_holding_register;
            weighting_filter_en <= switch_holding_register[isc_pkg::SWB_WEIGHTED];
            unweighted_amp_en   <= !switch_holding_register[isc_pkg::SWB_WEIGHTED];
            notch_en            <= notch_for_mode(
                                   switch_holding_register[isc_pkg::SWB_MODE_LO +: 2]);
            gain15_en           <= switch_holding_register[isc_pkg::SWB_GAIN15];
            gain30_en           <= switch_holding_register[isc_pkg::SWB_GAIN30];
            rms_long_tc_en      <= switch_holding_register[isc_pkg::SWB_AVERAGING_SELECT];
            calibration_oscillator_signal_out         <= osc_s
                                   && switch_holding_register[isc_pkg::SWB_CAL_GATE];
        end
    end
endmodule : isc_board
`default_nettype wire

/* hdl/isc_ctrl.sv */
/*
 * isc_ctrl: controller end. Serialises switch word and threshold code,
 * makes the shift clock by dividing sys_clk, polls the impulse counter.
 * Assumes the board end watches the latch through a two-flop synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module isc_ctrl #(
    parameter int POLL = isc_pkg::POLL_CYC          // one second, shortenable
) (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    isc_link_if.host                        link,
    input  wire logic                       load_start,
    input  wire logic [isc_pkg::SW_W-1:0]   switch_word,
    input  wire logic [isc_pkg::THR_W-1:0]  threshold_code,
    output logic                            load_busy,
    input  wire logic                       measure_start,
    input  wire logic [7:0]                 measure_seconds,
    output logic [15:0]                     impulse_total,
    output logic                            measure_busy,
    output logic                            measure_done
);
    // ------------------------------------------------------------------
    // serial loader
    // ------------------------------------------------------------------
    typedef enum {ISC_IDLE, ISC_LOW, ISC_HIGH, ISC_LATCH} isc_state_t;
    isc_state_t                   st, next_st;
    logic [isc_pkg::STREAM_W-1:0] sreg, next_sreg;    // msb goes out first
    logic [4:0]                   bits, next_bits;    // bits still to send
    logic [2:0]                   tmr, next_tmr;      // half-period / latch timer
    logic                         sck, next_sck;
    logic                         lat, next_lat;

    // new loads are ignored while busy
    always_comb begin
        next_st = st; next_sreg = sreg; next_bits = bits;
        next_tmr = tmr; next_sck = sck; next_lat = lat;
        case (st)
            ISC_IDLE: begin
                if (load_start) begin
                    next_sreg = {switch_word, threshold_code};
                    next_bits = 5'(isc_pkg::STREAM_W);
                    next_tmr  = 3'(isc_pkg::SCK_HALF_CYC - 1);
                    next_st   = ISC_LOW;
                end
            end
            ISC_LOW: begin
                if (tmr == 3'h0) begin
                    next_sck = 1'b1;
                    next_tmr = 3'(isc_pkg::SCK_HALF_CYC - 1);
                    next_st  = ISC_HIGH;
                end else next_tmr = tmr - 3'h1;
            end
            ISC_HIGH: begin
                if (tmr == 3'h0) begin
                    next_sck  = 1'b0;
                    next_sreg = sreg << 1;
                    next_bits = bits - 5'h01;
                    if (bits == 5'h01) begin
                        next_lat = 1'b1;
                        next_tmr = 3'(isc_pkg::LATCH_CYC - 1);
                        next_st  = ISC_LATCH;
                    end else begin
                        next_tmr = 3'(isc_pkg::SCK_HALF_CYC - 1);
                        next_st  = ISC_LOW;
                    end
                end else next_tmr = tmr - 3'h1;
            end
            ISC_LATCH: begin
                if (tmr == 3'h0) begin
                    next_lat = 1'b0;
                    next_st  = ISC_IDLE;
                end else next_tmr = tmr - 3'h1;
            end
            default: next_st = ISC_IDLE;
        endcase
    end

    // loader registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= ISC_IDLE; sreg <= '0; bits <= 5'h00;
            tmr <= 3'h0; sck <= 1'b0; lat <= 1'b0;
        end else begin
            st <= next_st; sreg <= next_sreg; bits <= next_bits;
            tmr <= next_tmr; sck <= next_sck; lat <= next_lat;
        end
    end

    assign link.option_shift_clock = sck;
    assign link.serial_data        = sreg[isc_pkg::STREAM_W-1];
    assign link.latch_strobe       = lat;
    assign load_busy               = (st != ISC_IDLE);

    // ------------------------------------------------------------------
    // counter polling and accumulation
    // ------------------------------------------------------------------
    logic [isc_pkg::CNT_W-1:0]   gray_s, cur, last, next_last;
    logic [isc_pkg::TIMER_W-1:0] sec_cnt, next_sec_cnt;
    logic [7:0]                  secs, next_secs;
    logic [15:0]                 next_total;
    logic                        next_mbusy, next_mdone;

    isc_sync2 #(.W(isc_pkg::CNT_W)) u_sync_cnt (
        .clk  (sys_clk),
        .rst  (sys_rst),
        .din  (link.count_gray),
        .dout (gray_s)
    );

    // gray to binary, then sample once per second and add the wrap-safe delta
    always_comb begin
        cur[3] = gray_s[3];
        for (int i = 2; i >= 0; i--) cur[i] = cur[i+1] ^ gray_s[i];
        next_last = last; next_sec_cnt = sec_cnt; next_secs = secs;
        next_total = impulse_total; next_mbusy = measure_busy; next_mdone = measure_done;
        if (measure_start && !measure_busy) begin
            next_last    = cur;
            next_total   = 16'h0000;
            next_secs    = measure_seconds;
            next_sec_cnt = POLL[isc_pkg::TIMER_W-1:0] - 28'h0000001;
            next_mbusy   = (measure_seconds != 8'h00);
            next_mdone   = (measure_seconds == 8'h00);
        end else if (measure_busy) begin
            if (sec_cnt == '0) begin
                next_last    = cur;
                next_total   = impulse_total + {12'h000, 4'(cur - last)};
                next_sec_cnt = POLL[isc_pkg::TIMER_W-1:0] - 28'h0000001;
                next_secs    = secs - 8'h01;
                if (secs == 8'h01) begin
                    next_mbusy = 1'b0;
                    next_mdone = 1'b1;
                end
            end else next_sec_cnt = sec_cnt - 28'h0000001;
        end
    end

    // total freezes once the period ends until the next start
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            last <= 4'h0; sec_cnt <= '0; secs <= 8'h00;
            impulse_total <= 16'h0000; measure_busy <= 1'b0; measure_done <= 1'b0;
        end else begin
            last <= next_last; sec_cnt <= next_sec_cnt; secs <= next_secs;
            impulse_total <= next_total; measure_busy <= next_mbusy;
            measure_done <= next_mdone;
        end
    end
endmodule : isc_ctrl
`default_nettype wire

/* testbench/isc_props.sv */
/* isc_props: link checks between controller end and board end.
   Assumes the bench instantiates it beside the link interface. */
`timescale 1ns/1ps
`default_nettype none
module isc_props (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       option_shift_clock,
    input  wire logic       serial_data,
    input  wire logic       latch_strobe,
    input  wire logic [3:0] count_gray
);
    // ------------------------------------------------------------
    // helper: shift clock rises since the last latch
    // ------------------------------------------------------------
    logic       sck_q;  // shift clock one cycle ago
    logic [4:0] rises;  // bits sent in this stream
    // cleared by the latch so each stream is counted on its own
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_q <= 1'b0;
            rises <= 5'h00;
        end else begin
            sck_q <= option_shift_clock;
            rises <= latch_strobe ? 5'h00 : rises + 5'(option_shift_clock & ~sck_q);
        end
    end
    // gray to binary, to see the count step by one
    function automatic logic [3:0] g2b(input logic [3:0] g);
        return g ^ (g >> 1) ^ (g >> 2) ^ (g >> 3);
    endfunction : g2b
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_latch_sck_low: assert property (latch_strobe |-> !option_shift_clock)
        else $error("latch while shift clock high");
    a_latch_width: assert property ($rose(latch_strobe) |-> latch_strobe[*4] ##1 !latch_strobe)
        else $error("latch width wrong");
    a_full_stream: assert property ($rose(latch_strobe) |-> rises == 5'(isc_pkg::STREAM_W))
        else $error("latch before full stream");
    a_stream_bound: assert property (rises <= 5'(isc_pkg::STREAM_W))
        else $error("too many shift clocks");
    a_sck_half: assert property ($rose(option_shift_clock) |-> option_shift_clock[*2] ##1 !option_shift_clock)
        else $error("shift clock half period wrong");
    a_data_stable: assert property (option_shift_clock |-> $stable(serial_data))
        else $error("data moved while shift clock high");
    a_gray_step: assert property ($changed(count_gray) |-> $onehot(count_gray ^ $past(count_gray)))
        else $error("count changed in more than one bit");
    a_count_up: assert property ($changed(count_gray) |-> g2b(count_gray) == g2b($past(count_gray)) + 4'h1)
        else $error("count did not step by one");
    c_latch: cover property ($rose(latch_strobe));
    c_wrap: cover property ($changed(count_gray) && count_gray == 4'h0);
    c_shift: cover property ($rose(option_shift_clock));
endmodule : isc_props
`default_nettype wire

/* testbench/impulse_count_serial_control_tb.sv */
/* impulse_count_serial_control_tb: both ends joined by the link.
   Assumes shortened dead times 50/40/10 and a 200-cycle poll. */
`timescale 1ns/1ps
`default_nettype none
module impulse_count_serial_control_tb;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        sys_clk = 1'b0, sys_rst = 1'b0, threshold_comparator = 1'b0;
    logic        calibration_oscillator_signal = 1'b1;  // held high: gate decides
    logic        load_start = 1'b0, measure_start = 1'b0;
    logic [7:0]  switch_word = 8'h00, measure_seconds = 8'h08;
    logic [5:0]  threshold_code = 6'h00, threshold_dac;
    logic [3:0]  impulse_counter;
    logic [15:0] impulse_total, c0;
    logic        dead_time_oneshot, weighting_filter_en, unweighted_amp_en, notch_en;
    logic        gain15_en, gain30_en, rms_long_tc_en, calibration_oscillator_signal_out;
    logic        load_busy, measure_busy, measure_done;
    int          err_total, num_checks, n;
    always #2 sys_clk = ~sys_clk;
    isc_link_if link ();
    isc_board #(.DEAD_SEVEN(50), .DEAD_CCITT(40), .DEAD_CAL(10)) isc_board_i (.sys_clk, .sys_rst,
        .link, .threshold_comparator, .calibration_oscillator_signal, .threshold_dac,
        .impulse_counter, .dead_time_oneshot, .weighting_filter_en, .unweighted_amp_en,
        .notch_en, .gain15_en, .gain30_en, .rms_long_tc_en, .calibration_oscillator_signal_out);
    isc_ctrl #(.POLL(200)) isc_ctrl_i (.sys_clk, .sys_rst, .link, .load_start, .switch_word,
        .threshold_code, .load_busy, .measure_start, .measure_seconds, .impulse_total,
        .measure_busy, .measure_done);
    isc_props isc_props_i (.sys_clk, .sys_rst, .option_shift_clock(link.option_shift_clock),
        .serial_data(link.serial_data), .latch_strobe(link.latch_strobe),
        .count_gray(link.count_gray));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task tally_and_finish;
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task tmo(input bit ok);  // a bounded wait ran out
        if (!ok) begin
            err_total++;
            tally_and_finish();
        end
    endtask : tmo
    // switch outputs packed: thr, weight, unweighted, notch, g15, g30, rms, cal
    function automatic logic [15:0] outs();
        return 16'({threshold_dac, weighting_filter_en, unweighted_amp_en, notch_en,
                    gain15_en, gain30_en, rms_long_tc_en, calibration_oscillator_signal_out});
    endfunction : outs
    task load(input logic [7:0] sw, input logic [5:0] thr);
        logic [5:0] prev;
        prev = threshold_dac;
        load_start <= 1'b1;
        switch_word <= sw;
        threshold_code <= thr;
        @(posedge sys_clk);
        load_start <= 1'b0;
        repeat (30) @(posedge sys_clk);
        chk(16'(threshold_dac), 16'(prev));
        for (n = 0; n < 100 && load_busy; n++) @(posedge sys_clk);
        tmo(n < 100);
        repeat (6) @(posedge sys_clk);
        chk(outs(), 16'({thr, sw[0], !sw[0], sw[7] ^ sw[6], sw[1], sw[2], sw[3], sw[4]}));
        calibration_oscillator_signal <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(16'(calibration_oscillator_signal_out), 16'h0000);
        calibration_oscillator_signal <= 1'b1;
    endtask : load
    // one impulse; a second rise inside the dead time must be lost
    task hit(input int len);
        c0 = 16'(impulse_counter);
        threshold_comparator <= 1'b1;
        for (n = 0; n < 20 && !dead_time_oneshot; n++) @(posedge sys_clk);
        tmo(n < 20);
        for (n = 0; n < 200 && dead_time_oneshot; n++) begin
            @(posedge sys_clk);
            threshold_comparator <= (n inside {3, 4});
        end
        chk(16'(n), 16'(len));
        chk(16'(impulse_counter), 16'(4'(c0[3:0] + 4'h1)));
    endtask : hit
    task fire;  // spaced wider than the dead time
        threshold_comparator <= 1'b1;
        repeat (2) @(posedge sys_clk);
        threshold_comparator <= 1'b0;
        repeat (58) @(posedge sys_clk);
    endtask : fire
    initial begin
        sys_rst <= 1'b1;  // a real edge, so the link-clock shifter clears too
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk(outs(), 16'h0020);
        for (int m = 0; m < 4; m++) begin
            load({2'(m), 6'h15 ^ {6{m[0]}}}, 6'h3B >> m);
        end
        hit(10);
        load(8'h00, 6'h00);
        hit(50);
        c0 = 16'(impulse_counter);
        measure_start <= 1'b1;
        @(posedge sys_clk);
        measure_start <= 1'b0;
        repeat (17) fire();
        for (n = 0; n < 3000 && !measure_done; n++) @(posedge sys_clk);
        tmo(n < 3000);
        chk(impulse_total, 16'h0011);
        repeat (2) fire();
        chk(impulse_total, 16'h0011);
        chk(16'(impulse_counter), 16'(4'(c0[3:0] + 4'h3)));
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        tmo(1'b0);
    end
endmodule : impulse_count_serial_control_tb
`default_nettype wire
